/* File: pwg_pkg.sv */
/*
 * Package of the three-phase PWM generator: register offsets, field
 * positions, reset values and the packed carriers shared by the design.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
package pwg_pkg;

   // Register byte offsets on the bus
   localparam logic [7:0] PWG_OFS_CTRL = 8'h00;
   localparam logic [7:0] PWG_OFS_STAT = 8'h04;
   localparam logic [7:0] PWG_OFS_PER = 8'h08;
   localparam logic [7:0] PWG_OFS_DEAD = 8'h0C;
   localparam logic [7:0] PWG_OFS_SWID = 8'h10;
   localparam logic [7:0] PWG_OFS_DUTY0 = 8'h14;
   localparam logic [7:0] PWG_OFS_DUTY1 = 8'h18;
   localparam logic [7:0] PWG_OFS_DUTY2 = 8'h1C;
   localparam logic [7:0] PWG_OFS_OCTL = 8'h20;
   localparam logic [7:0] PWG_OFS_CHOP = 8'h24;

   // Status register field positions
   localparam int PWG_STA_PHASE = 0;
   localparam int PWG_STA_TRIP = 3;
   localparam int PWG_STA_TRIPF = 8;
   localparam int PWG_STA_SYNCF = 9;

   // Output control field positions
   localparam int PWG_OC_XOVER_TOP = 8;
   localparam int PWG_OC_DIS_W = 6;

   // Reset values
   localparam logic [15:0] PWG_RST_16 = 16'h0000;
   localparam logic [8:0] PWG_RST_OCTL = 9'h000;
   localparam logic [9:0] PWG_RST_CHOP = 10'h000;
   localparam logic [4:0] PWG_RST_CTRL = 5'h00;
   localparam logic [3:0] PWG_REARM_ALL = 4'hF;

   // Main control fields, bit 4 down to bit 0
   typedef struct packed {
      logic sync_ext;    // Bit 4: take sync from the pin
      logic ext_is_sync; // Bit 3: pin sync already on our clock
      logic dbl;         // Bit 2: double update mode
      logic sync_en;     // Bit 1: drive the sync pulse out
      logic enable;      // Bit 0: generator enable
   } pwg_ctrl_t;

   // Gate-chop configuration, bit 9 down to bit 0
   typedef struct packed {
      logic lo_en;      // Bit 9: chop low-side outputs
      logic hi_en;      // Bit 8: chop high-side outputs
      logic [7:0] div;  // Bits 7..0: carrier divider
   } pwg_chop_t;

   // One phase pair of drive levels
   typedef struct packed {
      logic hi;
      logic lo;
   } pwg_pair_t;

endpackage

/* File: pwg_top.sv */
/*
 * Three-phase centre-based PWM generator with dead time, single or double
 * update, internal or external sync, gate chopping, output crossover and
 * per-output disables, reached over a classic Wishbone slave.
 * Assumes one 200 MHz clock, a synchronous active-high reset, and a trip
 * pin that is active low and may change at any time.
 */
`timescale 1ns/1ps
`default_nettype none

// Function
// R1: Outputs active high; high means switch on
// R2: Six outputs, three high/low phase pairs
// R3: Period, dead time, three duty registers
// R4: Crossover swaps high and low of pair
// R5: 8-bit chop divider, separate high/low enables
// R6: Single update loads duties once per period
// R7: Double update also reloads at midpoint
// R8: One control bit selects single/double update
// R9: Internal sync at start, midpoint if double
// R10: Sync pulse driven out, width from register
// R11: Control bit selects external sync pin
// R12: Asynchronous external sync goes through synchroniser
// R13: External sync pulse exceeds two clock periods
// R14: Trip low forces outputs off, unclocked
// R15: Status shows trip level and half flag
// R16: 9-bit output control; bits 8..6 crossover
// R17: Reset clears all crossover bits
// R18: Bits 0..5 disable one output each
// R19: Disables act after the crossover swap
// R20: Reset clears all disable bits
// R21: Duties and output control load at sync
// R22: Chop enables bits 8/9, divider 7..0
// R23: Chop carrier period is 4*(div+1) cycles
// R24: Trip flags, stops timing, clears enable
// R25: Rearm needs period and three duty writes
// R26: Dead time separates high and low edges
// R27: Up/down counter centred on period midpoint
module pwg_top
(
   input wire logic clk_i,              // 200 MHz core clock
   input wire logic rst_i,              // Synchronous reset, active high
   input wire logic wb_cyc_i,           // Wishbone cycle
   input wire logic wb_stb_i,           // Wishbone strobe
   input wire logic wb_we_i,            // Wishbone write enable
   input wire logic [7:0] wb_adr_i,     // Wishbone byte address
   input wire logic [3:0] wb_sel_i,     // Wishbone byte enables
   input wire logic [31:0] wb_dat_i,    // Wishbone write data
   output logic [31:0] wb_dat_o,        // Wishbone read data
   output logic wb_ack_o,               // Wishbone acknowledge
   input wire logic fault_shutdown_input_n_i, // Trip pin, low = fault
   input wire logic period_sync_pulse_i,  // Sync pin input level
   output logic period_sync_pulse_o,      // Sync pin output level
   output logic period_sync_pulse_oe_o,   // Sync pin output enable
   output logic phase0_high_out_o,      // Phase 0 high-side drive
   output logic phase0_low_out_o,       // Phase 0 low-side drive
   output logic phase1_high_out_o,      // Phase 1 high-side drive
   output logic phase1_low_out_o,       // Phase 1 low-side drive
   output logic phase2_high_out_o,      // Phase 2 high-side drive
   output logic phase2_low_out_o        // Phase 2 low-side drive
);
   import pwg_pkg::*;

   // Merge a 16-bit register with the two low write lanes
   function automatic logic [15:0] wr16(input logic [15:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] sel);
      logic [15:0] res;
      res = old;
      if (sel[0])
      begin
         res[7:0] = dat[7:0];
      end
      if (sel[1])
      begin
         res[15:8] = dat[15:8];
      end
      return res;
   endfunction

   // Dead-time spaced compare of one phase against the counter
   function automatic pwg_pair_t edge_cmp(input logic [15:0] cnt,
                                          input logic [15:0] duty,
                                          input logic [15:0] dt);
      pwg_pair_t res;
      logic [16:0] lead;
      logic [16:0] lag;
      lead = {1'b0, cnt} + {1'b0, dt};
      lag = {1'b0, duty} + {1'b0, dt};
      res.hi = lead < {1'b0, duty};
      res.lo = {1'b0, cnt} >= lag;
      return res;
   endfunction

   // Software registers
   pwg_ctrl_t ctrl_ff;                  // Main control
   logic [15:0] period_reg_ff;          // Half-period count
   logic [15:0] deadtime_reg_ff;        // Dead time in cycles
   logic [15:0] sync_width_reg_ff;      // Sync pulse width in cycles
   logic [15:0] duty_reg_ff [3];        // Duty per phase
   logic [8:0] octl_ff;                 // Crossover and disables
   pwg_chop_t chop_ff;                  // Gate-chop configuration
   logic trip_flag_ff;                  // Sticky trip event
   logic sync_flag_ff;                  // Sticky sync event
   logic [3:0] rearm_ff;                // Writes seen since last trip

   // Shadow copies used by the timing unit
   logic [15:0] duty_sh_ff [3];         // Latched duties
   logic [8:0] octl_sh_ff;              // Latched output control

   // Timing unit
   logic [15:0] cnt_ff;                 // Up/down counter
   logic down_ff;                       // High in first (down) half
   logic run_ff;                        // Timing ran last cycle
   logic [15:0] swid_cnt_ff;            // Remaining sync pulse cycles
   logic [9:0] chop_cnt_ff;             // Chop half-period counter
   logic chop_car_ff;                   // Chop carrier level
   logic [5:0] drv_ff;                  // Registered drive levels

   // Synchronisers
   logic trip_s1_ff;                    // Trip first stage
   logic trip_s2_ff;                    // Trip second stage
   logic trip_s3_ff;                    // Trip previous level
   logic sync_s1_ff;                    // Sync pin first stage
   logic sync_s2_ff;                    // Sync pin second stage
   logic sync_s3_ff;                    // Extra stage, async mode
   logic sync_prev_ff;                  // Last selected sync level

   // Bus strobes, timing events and combinational helpers
   logic bus_req;
   logic bus_wr;
   logic trip_evt;
   logic run;
   logic per_start;
   logic mid_pt;
   logic int_evt;
   logic ext_lvl;
   logic ext_edge;
   logic load_evt;
   logic [5:0] phys;
   logic [9:0] chop_half;

   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr = bus_req & wb_we_i;

   // Trip falling edge seen on the synchronised level
   assign trip_evt = trip_s3_ff & ~trip_s2_ff; // see R24

   // Timing runs only when enabled, rearmed and trip released
   assign run = ctrl_ff.enable & (rearm_ff == PWG_REARM_ALL) &
                trip_s2_ff; // see R25

   // Period start: first run cycle or the top of the up half
   assign per_start = run & (~run_ff |
                      (~down_ff & (cnt_ff >= period_reg_ff)));
   assign mid_pt = run & down_ff & (cnt_ff == PWG_RST_16);
   assign int_evt = per_start | (ctrl_ff.dbl & mid_pt); // see R9 R8

   // Async sync takes one more stage; adds a cycle of latency and jitter
   assign ext_lvl = ctrl_ff.ext_is_sync ? sync_s2_ff : sync_s3_ff; // see R12
   assign ext_edge = run & ext_lvl & ~sync_prev_ff;

   // Rising edge of the selected sync loads the shadows
   assign load_evt = ctrl_ff.sync_ext ?
                     (ext_edge | (ctrl_ff.dbl & mid_pt)) :
                     int_evt; // see R11 R21

   // Trip pin synchroniser and previous level for edge detection
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         trip_s1_ff <= 1'b1;
         trip_s2_ff <= 1'b1;
         trip_s3_ff <= 1'b1;
      end
      else
      begin
         trip_s1_ff <= fault_shutdown_input_n_i;
         trip_s2_ff <= trip_s1_ff;
         trip_s3_ff <= trip_s2_ff;
      end
   end

   // Sync pin synchroniser; pulses must outlast two clocks
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync_s1_ff <= 1'b0;
         sync_s2_ff <= 1'b0;
         sync_s3_ff <= 1'b0;
         sync_prev_ff <= 1'b0;
      end
      else
      begin
         sync_s1_ff <= period_sync_pulse_i; // see R13
         sync_s2_ff <= sync_s1_ff;
         sync_s3_ff <= sync_s2_ff;
         sync_prev_ff <= ext_lvl;
      end
   end

   // Main control; trip clears the enable, and trip wins over a write
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_ff <= pwg_ctrl_t'(PWG_RST_CTRL);
      end
      else
      begin
         if (bus_wr && wb_adr_i == PWG_OFS_CTRL && wb_sel_i[0])
         begin
            ctrl_ff <= pwg_ctrl_t'(wb_dat_i[4:0]); // see R8 R11 R12
         end
         if (trip_evt)
         begin
            ctrl_ff.enable <= 1'b0; // see R24
         end
      end
   end

   // Timing and dead-time registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         period_reg_ff <= PWG_RST_16;
         deadtime_reg_ff <= PWG_RST_16;
         sync_width_reg_ff <= PWG_RST_16;
      end
      else if (bus_wr)
      begin
         case (wb_adr_i)
            PWG_OFS_PER:
            begin
               period_reg_ff <= wr16(period_reg_ff, wb_dat_i,
                                     wb_sel_i); // see R3
            end
            PWG_OFS_DEAD:
            begin
               deadtime_reg_ff <= wr16(deadtime_reg_ff, wb_dat_i,
                                       wb_sel_i); // see R3
            end
            PWG_OFS_SWID:
            begin
               sync_width_reg_ff <= wr16(sync_width_reg_ff, wb_dat_i,
                                         wb_sel_i); // see R10
            end
            default:
            begin
               // Other addresses belong to other processes
            end
         endcase
      end
   end

   // Duty registers, one per phase pair
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 3; i++)
         begin
            duty_reg_ff[i] <= PWG_RST_16;
         end
      end
      else if (bus_wr)
      begin
         for (int i = 0; i < 3; i++)
         begin
            if (wb_adr_i == PWG_OFS_DUTY0 + 8'(4 * i))
            begin
               duty_reg_ff[i] <= wr16(duty_reg_ff[i], wb_dat_i,
                                      wb_sel_i); // see R3
            end
         end
      end
   end

   // Output control and chop configuration; both clear on reset
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         octl_ff <= PWG_RST_OCTL; // see R17 R20
         chop_ff <= pwg_chop_t'(PWG_RST_CHOP);
      end
      else if (bus_wr)
      begin
         if (wb_adr_i == PWG_OFS_OCTL)
         begin
            octl_ff <= 9'(wr16({7'h00, octl_ff}, wb_dat_i,
                               wb_sel_i)); // see R16
         end
         if (wb_adr_i == PWG_OFS_CHOP)
         begin
            chop_ff <= pwg_chop_t'(10'(wr16({6'h00, chop_ff}, wb_dat_i,
                                            wb_sel_i))); // see R5 R22
         end
      end
   end

   // Rearm mask: a trip clears it, writes to period and duties refill it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rearm_ff <= PWG_REARM_ALL;
      end
      else if (trip_evt)
      begin
         rearm_ff <= 4'h0; // see R25
      end
      else if (bus_wr)
      begin
         if (wb_adr_i == PWG_OFS_PER)
         begin
            rearm_ff[0] <= 1'b1;
         end
         for (int i = 0; i < 3; i++)
         begin
            if (wb_adr_i == PWG_OFS_DUTY0 + 8'(4 * i))
            begin
               rearm_ff[i + 1] <= 1'b1;
            end
         end
      end
   end

   // Sticky status flags; a new event wins over a write-one clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         trip_flag_ff <= 1'b0;
         sync_flag_ff <= 1'b0;
      end
      else
      begin
         if (trip_evt)
         begin
            trip_flag_ff <= 1'b1; // see R24
         end
         else if (bus_wr && wb_adr_i == PWG_OFS_STAT && wb_sel_i[1] &&
                  wb_dat_i[PWG_STA_TRIPF])
         begin
            trip_flag_ff <= 1'b0;
         end
         if (load_evt)
         begin
            sync_flag_ff <= 1'b1;
         end
         else if (bus_wr && wb_adr_i == PWG_OFS_STAT && wb_sel_i[1] &&
                  wb_dat_i[PWG_STA_SYNCF])
         begin
            sync_flag_ff <= 1'b0;
         end
      end
   end

   // Shadow load only at sync so a period never sees a half-written value
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         octl_sh_ff <= PWG_RST_OCTL;
         for (int i = 0; i < 3; i++)
         begin
            duty_sh_ff[i] <= PWG_RST_16;
         end
      end
      else if (load_evt)
      begin
         octl_sh_ff <= octl_ff; // see R21
         for (int i = 0; i < 3; i++)
         begin
            duty_sh_ff[i] <= duty_reg_ff[i]; // see R6 R7
         end
      end
   end

   // Up/down counter: down from the period to zero, then back up
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_ff <= PWG_RST_16;
         down_ff <= 1'b1;
         run_ff <= 1'b0;
      end
      else
      begin
         run_ff <= run;
         if (!run)
         begin
            cnt_ff <= period_reg_ff; // see R24
            down_ff <= 1'b1;
         end
         else if (per_start || (ctrl_ff.sync_ext && ext_edge))
         begin
            cnt_ff <= period_reg_ff; // see R27
            down_ff <= 1'b1;
         end
         else if (down_ff)
         begin
            if (cnt_ff == PWG_RST_16)
            begin
               down_ff <= 1'b0;
               cnt_ff <= cnt_ff + 16'h0001;
            end
            else
            begin
               cnt_ff <= cnt_ff - 16'h0001;
            end
         end
         else
         begin
            cnt_ff <= cnt_ff + 16'h0001;
         end
      end
   end

   // Sync pin pulse width counter, restarted by each internal sync
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         swid_cnt_ff <= PWG_RST_16;
      end
      else if (int_evt)
      begin
         swid_cnt_ff <= sync_width_reg_ff; // see R10
      end
      else if (swid_cnt_ff != PWG_RST_16)
      begin
         swid_cnt_ff <= swid_cnt_ff - 16'h0001;
      end
   end

   // Chop carrier toggles every 2*(div+1) cycles, a full period 4*(div+1)
   assign chop_half = {1'b0, chop_ff.div, 1'b1}; // see R23
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         chop_cnt_ff <= PWG_RST_CHOP;
         chop_car_ff <= 1'b0;
      end
      else if (chop_cnt_ff >= chop_half)
      begin
         chop_cnt_ff <= PWG_RST_CHOP;
         chop_car_ff <= ~chop_car_ff;
      end
      else
      begin
         chop_cnt_ff <= chop_cnt_ff + 10'h001;
      end
   end

   // Compare, crossover, disable and chop per physical pin
   // Index 5 is phase 0 high down to index 0 is phase 2 low
   always_comb
   begin
      pwg_pair_t tu;
      tu = '0;
      phys = 6'h00;
      for (int p = 0; p < 3; p++)
      begin
         tu = edge_cmp(cnt_ff, duty_sh_ff[p], deadtime_reg_ff); // see R26
         if (octl_sh_ff[PWG_OC_XOVER_TOP - p])
         begin
            phys[5 - 2 * p] = tu.lo; // see R4
            phys[4 - 2 * p] = tu.hi;
         end
         else
         begin
            phys[5 - 2 * p] = tu.hi; // see R2
            phys[4 - 2 * p] = tu.lo;
         end
         if (chop_ff.hi_en)
         begin
            phys[5 - 2 * p] = phys[5 - 2 * p] & chop_car_ff; // see R5
         end
         if (chop_ff.lo_en)
         begin
            phys[4 - 2 * p] = phys[4 - 2 * p] & chop_car_ff;
         end
      end
      phys = phys & ~octl_sh_ff[PWG_OC_DIS_W - 1:0]; // see R18 R19
   end

   // Drive levels come from flops; idle timing leaves every switch off
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         drv_ff <= 6'h00;
      end
      else
      begin
         drv_ff <= run_ff ? phys : 6'h00; // see R1
      end
   end

   // Trip gates the pins with no flop in the path, so it works clockless
   assign phase0_high_out_o = drv_ff[5] & fault_shutdown_input_n_i; // see R14
   assign phase0_low_out_o = drv_ff[4] & fault_shutdown_input_n_i;
   assign phase1_high_out_o = drv_ff[3] & fault_shutdown_input_n_i;
   assign phase1_low_out_o = drv_ff[2] & fault_shutdown_input_n_i;
   assign phase2_high_out_o = drv_ff[1] & fault_shutdown_input_n_i;
   assign phase2_low_out_o = drv_ff[0] & fault_shutdown_input_n_i;

   // Sync pin drives only for internal sync with output enabled
   assign period_sync_pulse_oe_o = ~ctrl_ff.sync_ext & ctrl_ff.sync_en;
   assign period_sync_pulse_o = (swid_cnt_ff != PWG_RST_16) &
                                fault_shutdown_input_n_i; // see R10

   // Bus answer: one-cycle ack, read data registered with it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= bus_req;
         wb_dat_o <= 32'h0000_0000;
         if (bus_req && !wb_we_i)
         begin
            case (wb_adr_i)
               PWG_OFS_CTRL: wb_dat_o <= {27'h0, ctrl_ff};
               PWG_OFS_STAT:
               begin
                  wb_dat_o[PWG_STA_PHASE] <= down_ff; // see R15
                  wb_dat_o[PWG_STA_TRIP] <= trip_s2_ff;
                  wb_dat_o[PWG_STA_TRIPF] <= trip_flag_ff;
                  wb_dat_o[PWG_STA_SYNCF] <= sync_flag_ff;
               end
               PWG_OFS_PER: wb_dat_o <= {16'h0, period_reg_ff};
               PWG_OFS_DEAD: wb_dat_o <= {16'h0, deadtime_reg_ff};
               PWG_OFS_SWID: wb_dat_o <= {16'h0, sync_width_reg_ff};
               PWG_OFS_DUTY0: wb_dat_o <= {16'h0, duty_reg_ff[0]};
               PWG_OFS_DUTY1: wb_dat_o <= {16'h0, duty_reg_ff[1]};
               PWG_OFS_DUTY2: wb_dat_o <= {16'h0, duty_reg_ff[2]};
               PWG_OFS_OCTL: wb_dat_o <= {23'h0, octl_ff};
               PWG_OFS_CHOP: wb_dat_o <= {22'h0, chop_ff};
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

/* File: pwg_props.sv */
/* Checker of the PWM generator, bound to pwg_top.
   Assumes the core clock and synchronous reset of the design. */
`timescale 1ns/1ps
`default_nettype none
module pwg_props
(
   input wire logic clk_i, // Core clock
   input wire logic rst_i, // Reset
   input wire logic wb_cyc_i, // Bus cycle
   input wire logic wb_stb_i, // Bus strobe
   input wire logic [31:0] wb_dat_o, // Read data
   input wire logic wb_ack_o, // Acknowledge
   input wire logic fault_shutdown_input_n_i, // Trip pin
   input wire logic period_sync_pulse_o, // Sync out
   input wire logic phase0_high_out_o, // Drives
   input wire logic phase0_low_out_o,
   input wire logic phase1_high_out_o,
   input wire logic phase1_low_out_o,
   input wire logic phase2_high_out_o,
   input wire logic phase2_low_out_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Any switch on at all
   wire logic on = phase0_high_out_o | phase0_low_out_o |
      phase1_high_out_o | phase1_low_out_o |
      phase2_high_out_o | phase2_low_out_o;
   a_ack_follows:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   a_ack_single:
      assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack long");
   a_dat_idle:
      assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("data without ack");
   // Trip gating is unclocked, so it must hold on the very edge
   a_trip_outs:
      assert property (!fault_shutdown_input_n_i |-> !on)
      else $error("drive under trip");
   a_trip_sync:
      assert property (!fault_shutdown_input_n_i |-> !period_sync_pulse_o)
      else $error("sync under trip");
   a_leg0_excl:
      assert property (!(phase0_high_out_o && phase0_low_out_o))
      else $error("leg 0 shoot through");
   a_leg1_excl:
      assert property (!(phase1_high_out_o && phase1_low_out_o))
      else $error("leg 1 shoot through");
   a_leg2_excl:
      assert property (!(phase2_high_out_o && phase2_low_out_o))
      else $error("leg 2 shoot through");
   a_reset_quiet:
      assert property (disable iff (1'b0) rst_i |=> !on && !wb_ack_o)
      else $error("active after reset");
endmodule
bind pwg_top pwg_props pwg_props_i
(
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .fault_shutdown_input_n_i(fault_shutdown_input_n_i),
   .period_sync_pulse_o(period_sync_pulse_o),
   .phase0_high_out_o(phase0_high_out_o),
   .phase0_low_out_o(phase0_low_out_o),
   .phase1_high_out_o(phase1_high_out_o),
   .phase1_low_out_o(phase1_low_out_o),
   .phase2_high_out_o(phase2_high_out_o),
   .phase2_low_out_o(phase2_low_out_o)
);
`default_nettype wire

/* File: pwg_ext_sync.sv */
/* External sync source model, push-pull onto the sync pin.
   Assumes the core clock; one pulse per fire request. */
`timescale 1ns/1ps
`default_nettype none
module pwg_ext_sync
(
   input wire logic clk_i, // Core clock
   input wire logic fire_i, // Start one pulse
   output logic sync_o // Pin drive
);
   logic [1:0] cnt_ff = 2'h0; // Cycles left
   // Three cycles, kept above the two-clock minimum
   always_ff @(posedge clk_i)
   begin
      if (fire_i)
         cnt_ff <= 2'h3;
      else if (cnt_ff != 2'h0)
         cnt_ff <= cnt_ff - 2'h1;
   end
   assign sync_o = (cnt_ff != 2'h0);
endmodule
`default_nettype wire

/* File: pwg_top_bench.sv */
/* Self-checking bench of the PWM generator.
   Assumes pwg_pkg, pwg_top, pwg_props and pwg_ext_sync compiled first. */
`timescale 1ns/1ps
`default_nettype none
module pwg_top_bench;
   import pwg_pkg::*;
   logic clk_i = 1'b0; // Core clock
   logic rst_i = 1'b1; // Reset
   logic cyc = 1'b0; // Cycle and strobe together
   logic we = 1'b0; // Direction
   logic [7:0] adr = 8'h00; // Address
   logic [31:0] wdat = 32'h0000_0000; // Write data
   logic [31:0] rdat; // Read data
   logic ack, ext, s_o, s_oe, h0, l0, h1, l1, h2, l2; // Outputs
   logic trip_n = 1'b1; // Trip pin, healthy
   logic fire = 1'b0; // Pulse request
   logic [15:0] hc, lc, sc, oc; // Counts over one period
   int fails = 0;
   int n_compared = 0;
   // Pin level: the device when it drives, else the source
   wire logic pin = s_oe ? s_o : ext;
   pwg_top pwg_top_i
   (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack),
      .fault_shutdown_input_n_i(trip_n), .period_sync_pulse_i(pin),
      .period_sync_pulse_o(s_o), .period_sync_pulse_oe_o(s_oe),
      .phase0_high_out_o(h0), .phase0_low_out_o(l0),
      .phase1_high_out_o(h1), .phase1_low_out_o(l1),
      .phase2_high_out_o(h2), .phase2_low_out_o(l2)
   );
   pwg_ext_sync pwg_ext_sync_i (.clk_i(clk_i), .fire_i(fire), .sync_o(ext));
   initial
   begin
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic wrap_up();
      if (fails == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e)
      begin
         fails++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask
   // One classic cycle; waits on ack, then idles one cycle
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [15:0] d, output logic [15:0] q);
      int i;
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {16'h0000, d};
      for (i = 0; i < 50 && ack !== 1'b1; i++)
         @(posedge clk_i);
      if (i == 50)
      begin
         fails++;
         wrap_up();
      end
      q = rdat[15:0];
      cyc <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [15:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [15:0] m,
      input logic [15:0] e);
      logic [15:0] q;
      wb(1'b0, a, 16'h0000, q);
      chk(q & m, e);
   endtask
   // Settle 20 cycles, then count one 9-cycle period
   task automatic meas();
      repeat (20) @(posedge clk_i);
      hc = 16'h0000;
      lc = 16'h0000;
      sc = 16'h0000;
      oc = 16'h0000;
      repeat (9)
      begin
         @(negedge clk_i);
         hc += 16'(h0);
         lc += 16'(l0);
         sc += 16'(s_o);
         oc += 16'(h1) + 16'(l1) + 16'(h2) + 16'(l2);
      end
   endtask
   task automatic t_regs();
      rdc(PWG_OFS_OCTL, 16'hFFFF, 16'h0000);
      wr(PWG_OFS_CHOP, 16'h03FF);
      rdc(PWG_OFS_CHOP, 16'hFFFF, 16'h03FF);
      wr(PWG_OFS_CHOP, 16'h0000);
      wr(PWG_OFS_OCTL, 16'h01FF);
      rdc(PWG_OFS_OCTL, 16'hFFFF, 16'h01FF);
      wr(PWG_OFS_OCTL, 16'h0000);
      rdc(8'h3C, 16'hFFFF, 16'h0000);
   endtask
   // Period 4, duty 2, no dead time: high 3 of 9 cycles
   task automatic t_wave(input logic [15:0] ctl);
      wr(PWG_OFS_PER, 16'h0004);
      wr(PWG_OFS_DUTY0, 16'h0002);
      wr(PWG_OFS_DUTY1, 16'h0002);
      wr(PWG_OFS_DUTY2, 16'h0002);
      wr(PWG_OFS_CTRL, ctl);
      meas();
   endtask
   task automatic t_trip();
      @(posedge clk_i);
      trip_n <= 1'b0;
      repeat (6) @(posedge clk_i);
      rdc(PWG_OFS_STAT, 16'h0108, 16'h0100);
      rdc(PWG_OFS_CTRL, 16'h0001, 16'h0000);
      trip_n <= 1'b1;
      t_wave(16'h0003);
      chk(lc, 16'h0003);
   endtask
   // Pin sync restarts the count: first half just after
   task automatic t_ext();
      wr(PWG_OFS_PER, 16'h0064);
      wr(PWG_OFS_CTRL, 16'h001B);
      chk({15'h0000, s_oe}, 16'h0000);
      wr(PWG_OFS_STAT, 16'h0200);
      rdc(PWG_OFS_STAT, 16'h0200, 16'h0000);
      fire <= 1'b1;
      @(posedge clk_i);
      fire <= 1'b0;
      repeat (12) @(posedge clk_i);
      rdc(PWG_OFS_STAT, 16'h0201, 16'h0201);
   endtask
   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      wr(PWG_OFS_DEAD, 16'h0000);
      wr(PWG_OFS_SWID, 16'h0003);
      t_wave(16'h0003);
      chk(hc, 16'h0003);
      chk(lc, 16'h0006);
      chk(sc, 16'h0003);
      chk(oc, 16'h0012);
      t_wave(16'h0007);
      chk(sc, 16'h0006);
      wr(PWG_OFS_OCTL, 16'h0123);
      meas();
      chk(hc, 16'h0000);
      chk(lc, 16'h0003);
      chk(oc, 16'h0009);
      t_trip();
      t_ext();
      wrap_up();
   end
endmodule
`default_nettype wire
